/* verilog/hbd_map.vh */
// constants for the host bus dma cycle sequencer
// Function
// - in cycle-steal mode every host bus transfer starts with the extended-address state.
// - in burst mode the extended-address state comes only on the first transfer and after a carry out of address bit 15.
// - the extended-address strobe pulses high then low in the extended-address state, the address strobe likewise in bus state 1.
// - on a read the address/data and parity lines float in bus state 1 before the read strobe falls.
// - on a read the read strobe falls on the falling edge in bus state 2 and rises on the falling edge in bus state 4.
// - on a read the buffer enable falls on the rising edge in bus state 2 and rises on the falling edge in bus state 4.
// - on a read the data and parity are captured at the rising edge that ends bus state 3 or the last wait state.
// - ready is asynchronous and is judged once per bus clock at the falling edge.
// - on a write the buffer enable falls on the rising edge of bus state 1 and rises on the rising edge of bus state 4.
// - on a write data, parity and the write strobe all go active on the falling edge in bus state 2.
// - on a write data stays driven about one and a half clocks and buffer enable about half a clock after the write strobe rises.
// - in 8-bit mode the byte-high/rnw pin is a high output during dma and an ignored input during direct-io.
// - in 8-bit mode the top address byte stays on the high lines through bus states 2 to 4 and past the end of state 4.
// - the chip-select input is ignored while the sequencer owns the host bus.
// - the bus-owned output goes low in the second idle state on taking the bus and high in it on giving the bus back.
`ifndef HBD_MAP_VH
`define HBD_MAP_VH
`define HBD_CNT_W 16
`define HBD_FIFO_W 18
`define HBD_FIFO_D 16
`define HBD_CARRY_BIT 16
`define HBD_INC16 17'h00002
`define HBD_INC8 17'h00001
`define HBD_CNT_ONE 16'h0001
`define HBD_BYTE_ZERO 8'h00
`define HBD_ADDR_ZERO 32'h0000_0000
`define HBD_WORD_ZERO 18'h00000
`endif

/* verilog/hbd_fifo.v */
// write data fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hbd_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16
) (
    input wire clk_in,
    input wire srst_in,
    input wire [WIDTH-1:0] s_data_in,
    input wire s_valid_in,
    output wire s_ready_out,
    output wire [WIDTH-1:0] m_data_out,
    output wire m_valid_out,
    input wire m_ready_in
);
    localparam AW = $clog2(DEPTH);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;
    assign s_ready_out = (cnt_r != DEPTH[AW:0]);
    assign m_valid_out = (cnt_r != {(AW+1){1'b0}});
    assign m_data_out = mem_r[rp_r];
    assign push = s_valid_in & s_ready_out;
    assign pop = m_valid_out & m_ready_in;
    always @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= s_data_in;
        end
    end
    always @(posedge clk_in) begin
        if (srst_in) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            // depth is a power of two, so the pointers wrap by themselves
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/hbd_seq_top.v */
// host bus dma cycle sequencer, separate read/write strobe bus mode
`timescale 1ns/1ps
`default_nettype none
`include "hbd_map.vh"
module hbd_seq_top #(
    parameter CNT_W = `HBD_CNT_W,
    parameter FIFO_DEPTH = `HBD_FIFO_D
) (
    input wire CLK_IN,
    input wire SRST_IN,
    input wire DMA_START_IN,
    input wire [31:0] DMA_ADDR_IN,
    input wire [CNT_W-1:0] DMA_COUNT_IN,
    input wire DMA_RNW_IN,
    input wire BURST_MODE_IN,
    input wire BUS8_MODE_IN,
    output wire DMA_BUSY_OUT,
    output reg DMA_DONE_OUT,
    input wire [17:0] WR_WORD_IN,
    input wire WR_VALID_IN,
    output wire WR_READY_OUT,
    output reg [17:0] RD_WORD_OUT,
    output reg RD_VALID_OUT,
    output wire HOST_BUS_CLOCK_OUT,
    input wire [7:0] ADDR_DATA_HIGH_IN,
    output reg [7:0] ADDR_DATA_HIGH_OUT,
    output reg ADDR_DATA_HIGH_OE_OUT,
    input wire [7:0] ADDR_DATA_LOW_IN,
    output reg [7:0] ADDR_DATA_LOW_OUT,
    output reg ADDR_DATA_LOW_OE_OUT,
    input wire PARITY_HIGH_IN,
    output reg PARITY_HIGH_OUT,
    input wire PARITY_LOW_IN,
    output reg PARITY_LOW_OUT,
    output reg ADDR_LATCH_STROBE_OUT,
    output reg EXT_ADDR_LATCH_STROBE_OUT,
    output reg READ_STROBE_N_OUT,
    output reg WRITE_STROBE_N_OUT,
    output reg STROBE_OE_OUT,
    output reg BUFFER_ENABLE_N_OUT,
    input wire BUS_READY_N_IN,
    output reg BUS_OWNED_N_OUT,
    input wire CHIP_SELECT_N_IN,
    output reg DIRECT_IO_SELECT_OUT,
    input wire BYTE_HIGH_RNW_IN,
    output reg BYTE_HIGH_RNW_OUT,
    output reg BYTE_HIGH_RNW_OE_OUT,
    output reg DIRECT_IO_BYTE_HIGH_OUT
);
    localparam [11:0] S_IDLE = 12'h001;
    localparam [11:0] S_AI1 = 12'h002;
    localparam [11:0] S_AI2 = 12'h004;
    localparam [11:0] S_OWN = 12'h008;
    localparam [11:0] S_TX = 12'h010;
    localparam [11:0] S_T1 = 12'h020;
    localparam [11:0] S_T2 = 12'h040;
    localparam [11:0] S_T3 = 12'h080;
    localparam [11:0] S_TW = 12'h100;
    localparam [11:0] S_T4 = 12'h200;
    localparam [11:0] S_RI1 = 12'h400;
    localparam [11:0] S_RI2 = 12'h800;

    reg [11:0] st_r;
    reg [11:0] st_nxt;
    reg ph_r;
    wire ph_nxt;
    wire adv;
    reg pend_r;
    reg [31:0] addr_r;
    reg [CNT_W-1:0] cnt_r;
    reg rnw_r;
    reg burst_r;
    reg b8_r;
    reg need_tx_r;
    reg rdy1_r;
    reg rdy2_r;
    reg rdy_seen_r;
    reg rdy_seen_nxt;
    wire [17:0] fifo_word;
    wire fifo_vld;
    wire fifo_pop;
    wire [16:0] low_sum;
    wire t4_end;
    wire cap;

    reg ale_nxt;
    reg xal_nxt;
    reg rd_n_nxt;
    reg wr_n_nxt;
    reg dben_n_nxt;
    reg own_n_nxt;
    reg lo_oe_nxt;
    reg hi_oe_nxt;
    reg [7:0] lo_nxt;
    reg [7:0] hi_nxt;
    reg pl_nxt;
    reg ph_par_nxt;
    reg owned_nxt;

    // the sequencer runs at twice the bus clock: phase 0 is the high half, phase 1 the low half
    assign ph_nxt = ~ph_r;
    assign adv = ph_r;
    assign HOST_BUS_CLOCK_OUT = ~ph_r;
    assign DMA_BUSY_OUT = ~st_r[0];
    assign t4_end = adv & (st_r == S_T4);
    assign cap = adv & ((st_r == S_T3) | (st_r == S_TW)) & rdy_seen_r;
    assign fifo_pop = t4_end & ~rnw_r;
    assign low_sum = {1'b0, addr_r[15:0]} + (b8_r ? `HBD_INC8 : `HBD_INC16);

    hbd_fifo #(
        .WIDTH(`HBD_FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .s_data_in(WR_WORD_IN),
        .s_valid_in(WR_VALID_IN),
        .s_ready_out(WR_READY_OUT),
        .m_data_out(fifo_word),
        .m_valid_out(fifo_vld),
        .m_ready_in(fifo_pop)
    );

    always @* begin
        st_nxt = st_r;
        if (adv) begin
            case (st_r)
                S_IDLE: begin
                    if (pend_r) begin
                        st_nxt = S_AI1;
                    end
                end
                S_AI1: begin
                    st_nxt = S_AI2;
                end
                S_AI2: begin
                    st_nxt = S_OWN;
                end
                S_OWN: begin
                    // writes stall here until the fifo holds a word
                    if (cnt_r == {CNT_W{1'b0}}) begin
                        st_nxt = S_RI1;
                    end else if (rnw_r | fifo_vld) begin
                        st_nxt = (need_tx_r | ~burst_r) ? S_TX : S_T1;
                    end
                end
                S_TX: begin
                    st_nxt = S_T1;
                end
                S_T1: begin
                    st_nxt = S_T2;
                end
                S_T2: begin
                    st_nxt = S_T3;
                end
                S_T3, S_TW: begin
                    st_nxt = rdy_seen_r ? S_T4 : S_TW;
                end
                S_T4: begin
                    st_nxt = S_OWN;
                end
                S_RI1: begin
                    st_nxt = S_RI2;
                end
                S_RI2: begin
                    st_nxt = S_IDLE;
                end
                default: begin
                    st_nxt = S_IDLE;
                end
            endcase
        end
    end

    // ready is judged only on the edge into the low half of t3 or a wait state
    always @* begin
        rdy_seen_nxt = rdy_seen_r;
        if (~ph_r & ((st_r == S_T3) | (st_r == S_TW))) begin
            rdy_seen_nxt = rdy2_r;
        end else if (st_r == S_T2) begin
            rdy_seen_nxt = 1'b0;
        end
    end

    // strobe and pin levels for the half clock about to start
    always @* begin
        owned_nxt = (st_nxt == S_OWN) | (st_nxt == S_TX) | (st_nxt == S_T1) |
                    (st_nxt == S_T2) | (st_nxt == S_T3) | (st_nxt == S_TW) |
                    (st_nxt == S_T4) | (st_nxt == S_RI1);
        own_n_nxt = ~(owned_nxt | ((st_nxt == S_AI2) & ph_nxt) |
                      ((st_nxt == S_RI2) & ~ph_nxt));
        xal_nxt = (st_nxt == S_TX) & ~ph_nxt;
        ale_nxt = (st_nxt == S_T1) & ~ph_nxt;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        dben_n_nxt = 1'b1;
        if (rnw_r) begin
            rd_n_nxt = ~(((st_nxt == S_T2) & ph_nxt) | (st_nxt == S_T3) |
                         (st_nxt == S_TW) | ((st_nxt == S_T4) & ~ph_nxt));
            dben_n_nxt = ~((st_nxt == S_T2) | (st_nxt == S_T3) |
                           (st_nxt == S_TW) | ((st_nxt == S_T4) & ~ph_nxt));
        end else begin
            // write strobe rises on the ready edge, so buffer enable trails it by half a clock
            wr_n_nxt = ~(((st_nxt == S_T2) & ph_nxt) |
                         (((st_nxt == S_T3) | (st_nxt == S_TW)) &
                          (~ph_nxt | ~rdy_seen_nxt)));
            dben_n_nxt = ~((st_nxt == S_T1) | (st_nxt == S_T2) |
                           (st_nxt == S_T3) | (st_nxt == S_TW));
        end
        lo_oe_nxt = 1'b0;
        lo_nxt = `HBD_BYTE_ZERO;
        hi_nxt = `HBD_BYTE_ZERO;
        pl_nxt = 1'b0;
        ph_par_nxt = 1'b0;
        if (st_nxt == S_TX) begin
            lo_oe_nxt = 1'b1;
            hi_nxt = addr_r[31:24];
            lo_nxt = addr_r[23:16];
        end else if ((st_nxt == S_T1) | ((st_nxt == S_T2) & ~ph_nxt)) begin
            // a read floats the lines in the low half of t1, ahead of the read strobe
            lo_oe_nxt = ~rnw_r | ((st_nxt == S_T1) & ~ph_nxt);
            hi_nxt = addr_r[15:8];
            lo_nxt = addr_r[7:0];
        end else if (~rnw_r & ((st_nxt == S_T2) | (st_nxt == S_T3) |
                               (st_nxt == S_TW) | (st_nxt == S_T4))) begin
            // data held through t4, a clock and a half after the write strobe rises
            lo_oe_nxt = 1'b1;
            hi_nxt = b8_r ? addr_r[15:8] : fifo_word[15:8];
            lo_nxt = fifo_word[7:0];
        end else if (b8_r) begin
            hi_nxt = addr_r[15:8];
        end
        if (lo_oe_nxt & ~((st_nxt != S_TX) & (st_nxt != S_T1) & ~rnw_r &
                          ~((st_nxt == S_T2) & ~ph_nxt))) begin
            pl_nxt = ~^lo_nxt;
            ph_par_nxt = ~^hi_nxt;
        end else begin
            pl_nxt = fifo_word[16];
            ph_par_nxt = fifo_word[17];
        end
        // 8-bit mode keeps the top address byte on the high lines into the half clock after t4
        hi_oe_nxt = lo_oe_nxt | (b8_r & ((st_nxt == S_T1) | (st_nxt == S_T2) |
                    (st_nxt == S_T3) | (st_nxt == S_TW) | (st_nxt == S_T4) |
                    ((st_r == S_T4) & ph_r)));
    end

    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            st_r <= S_IDLE;
            ph_r <= 1'b0;
            pend_r <= 1'b0;
            addr_r <= `HBD_ADDR_ZERO;
            cnt_r <= {CNT_W{1'b0}};
            rnw_r <= 1'b1;
            burst_r <= 1'b0;
            b8_r <= 1'b0;
            need_tx_r <= 1'b1;
            rdy1_r <= 1'b0;
            rdy2_r <= 1'b0;
            rdy_seen_r <= 1'b0;
            DMA_DONE_OUT <= 1'b0;
            RD_WORD_OUT <= `HBD_WORD_ZERO;
            RD_VALID_OUT <= 1'b0;
        end else begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            // two flops, since ready comes from the slave with no timing relation
            rdy1_r <= ~BUS_READY_N_IN;
            rdy2_r <= rdy1_r;
            rdy_seen_r <= rdy_seen_nxt;
            DMA_DONE_OUT <= adv & (st_r == S_RI2);
            RD_VALID_OUT <= cap & rnw_r;
            // a new job is taken only while idle and not already pending
            if ((st_r == S_IDLE) & ~pend_r & DMA_START_IN) begin
                pend_r <= 1'b1;
                addr_r <= DMA_ADDR_IN;
                cnt_r <= DMA_COUNT_IN;
                rnw_r <= DMA_RNW_IN;
                burst_r <= BURST_MODE_IN;
                b8_r <= BUS8_MODE_IN;
                need_tx_r <= 1'b1;
            end else if (adv & (st_r == S_IDLE)) begin
                pend_r <= 1'b0;
            end
            if (cap & rnw_r) begin
                RD_WORD_OUT <= {PARITY_HIGH_IN, PARITY_LOW_IN,
                                ADDR_DATA_HIGH_IN, ADDR_DATA_LOW_IN};
            end
            if (t4_end) begin
                addr_r <= {addr_r[31:16] + {15'h0000, low_sum[`HBD_CARRY_BIT]},
                           low_sum[15:0]};
                cnt_r <= cnt_r - `HBD_CNT_ONE;
                need_tx_r <= ~burst_r | low_sum[`HBD_CARRY_BIT];
            end
        end
    end

    // pin registers, loaded from the half-clock decode so pins never glitch
    always @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ADDR_LATCH_STROBE_OUT <= 1'b0;
            EXT_ADDR_LATCH_STROBE_OUT <= 1'b0;
            READ_STROBE_N_OUT <= 1'b1;
            WRITE_STROBE_N_OUT <= 1'b1;
            STROBE_OE_OUT <= 1'b0;
            BUFFER_ENABLE_N_OUT <= 1'b1;
            BUS_OWNED_N_OUT <= 1'b1;
            ADDR_DATA_HIGH_OUT <= `HBD_BYTE_ZERO;
            ADDR_DATA_LOW_OUT <= `HBD_BYTE_ZERO;
            ADDR_DATA_HIGH_OE_OUT <= 1'b0;
            ADDR_DATA_LOW_OE_OUT <= 1'b0;
            PARITY_HIGH_OUT <= 1'b0;
            PARITY_LOW_OUT <= 1'b0;
            BYTE_HIGH_RNW_OUT <= 1'b1;
            BYTE_HIGH_RNW_OE_OUT <= 1'b0;
            DIRECT_IO_SELECT_OUT <= 1'b0;
            DIRECT_IO_BYTE_HIGH_OUT <= 1'b0;
        end else begin
            ADDR_LATCH_STROBE_OUT <= ale_nxt;
            EXT_ADDR_LATCH_STROBE_OUT <= xal_nxt;
            READ_STROBE_N_OUT <= rd_n_nxt;
            WRITE_STROBE_N_OUT <= wr_n_nxt;
            STROBE_OE_OUT <= owned_nxt;
            BUFFER_ENABLE_N_OUT <= dben_n_nxt;
            BUS_OWNED_N_OUT <= own_n_nxt;
            ADDR_DATA_HIGH_OUT <= hi_nxt;
            ADDR_DATA_LOW_OUT <= lo_nxt;
            ADDR_DATA_HIGH_OE_OUT <= hi_oe_nxt;
            ADDR_DATA_LOW_OE_OUT <= lo_oe_nxt;
            PARITY_HIGH_OUT <= ph_par_nxt;
            PARITY_LOW_OUT <= pl_nxt;
            BYTE_HIGH_RNW_OUT <= 1'b1;
            BYTE_HIGH_RNW_OE_OUT <= b8_r & owned_nxt;
            // chip select is masked for as long as the bus is ours
            DIRECT_IO_SELECT_OUT <= ~CHIP_SELECT_N_IN & own_n_nxt;
            DIRECT_IO_BYTE_HIGH_OUT <= ~BUS8_MODE_IN & BYTE_HIGH_RNW_IN;
        end
    end
endmodule
`default_nettype wire

/* tb/hbd_seq_top_asserts.sv */
// concurrent checks on the dma sequencer pins
`timescale 1ns/1ps
`default_nettype none
module hbd_seq_top_asserts (
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic HOST_BUS_CLOCK_OUT,
    input wire logic ADDR_DATA_LOW_OE_OUT,
    input wire logic ADDR_LATCH_STROBE_OUT,
    input wire logic EXT_ADDR_LATCH_STROBE_OUT,
    input wire logic READ_STROBE_N_OUT,
    input wire logic WRITE_STROBE_N_OUT,
    input wire logic BUFFER_ENABLE_N_OUT,
    input wire logic BUS_READY_N_IN,
    input wire logic BUS_OWNED_N_OUT,
    input wire logic DIRECT_IO_SELECT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    sequence xal_then_ale;
        HOST_BUS_CLOCK_OUT ##1 !EXT_ADDR_LATCH_STROBE_OUT ##1 ADDR_LATCH_STROBE_OUT;
    endsequence
    // data must outlast the write strobe by a bus clock and a half, enable by half
    sequence wr_tail;
        ADDR_DATA_LOW_OE_OUT && !BUFFER_ENABLE_N_OUT
        ##1 ADDR_DATA_LOW_OE_OUT && BUFFER_ENABLE_N_OUT ##1 ADDR_DATA_LOW_OE_OUT;
    endsequence
    xal_order_a: assert property ($rose(EXT_ADDR_LATCH_STROBE_OUT) |-> xal_then_ale)
        else $error("ext latch strobe misplaced");
    ale_pulse_a: assert property (
        ADDR_LATCH_STROBE_OUT |-> HOST_BUS_CLOCK_OUT ##1 !ADDR_LATCH_STROBE_OUT)
        else $error("address latch strobe misplaced");
    rd_float_a: assert property ($fell(READ_STROBE_N_OUT) |->
        !ADDR_DATA_LOW_OE_OUT && !$past(ADDR_DATA_LOW_OE_OUT, 2)) else $error("lines not freed");
    rd_low_len_a: assert property ($fell(READ_STROBE_N_OUT) |-> !READ_STROBE_N_OUT [*4])
        else $error("read strobe too short");
    rd_release_a: assert property ($rose(READ_STROBE_N_OUT) |->
        $rose(BUFFER_ENABLE_N_OUT) && !HOST_BUS_CLOCK_OUT) else $error("read end misplaced");
    rd_dben_lead_a: assert property ($fell(READ_STROBE_N_OUT) |->
        !$past(BUFFER_ENABLE_N_OUT) && $past(BUFFER_ENABLE_N_OUT, 2)) else $error("read enable");
    wr_launch_a: assert property ($fell(WRITE_STROBE_N_OUT) |->
        !HOST_BUS_CLOCK_OUT && ADDR_DATA_LOW_OE_OUT && $past(ADDR_LATCH_STROBE_OUT, 3)
        && !$past(BUFFER_ENABLE_N_OUT, 3) && $past(BUFFER_ENABLE_N_OUT, 4))
        else $error("write start misplaced");
    wr_hold_a: assert property ($rose(WRITE_STROBE_N_OUT) |-> wr_tail)
        else $error("write hold too short");
    rd_wait_a: assert property (
        (BUS_READY_N_IN && !READ_STROBE_N_OUT) [*8] |=> !READ_STROBE_N_OUT)
        else $error("read ended without ready");
    wr_wait_a: assert property (
        (BUS_READY_N_IN && !WRITE_STROBE_N_OUT) [*6] |=> !WRITE_STROBE_N_OUT)
        else $error("write ended without ready");
    own_edge_a: assert property ($changed(BUS_OWNED_N_OUT) |-> !HOST_BUS_CLOCK_OUT)
        else $error("ownership edge misplaced");
    cs_block_a: assert property (
        !BUS_OWNED_N_OUT && !$past(BUS_OWNED_N_OUT) |-> !DIRECT_IO_SELECT_OUT)
        else $error("chip select seen while owning");
endmodule
bind hbd_seq_top hbd_seq_top_asserts u_chk (
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .HOST_BUS_CLOCK_OUT(HOST_BUS_CLOCK_OUT),
    .ADDR_DATA_LOW_OE_OUT(ADDR_DATA_LOW_OE_OUT), .ADDR_LATCH_STROBE_OUT(ADDR_LATCH_STROBE_OUT),
    .EXT_ADDR_LATCH_STROBE_OUT(EXT_ADDR_LATCH_STROBE_OUT), .READ_STROBE_N_OUT(READ_STROBE_N_OUT),
    .WRITE_STROBE_N_OUT(WRITE_STROBE_N_OUT), .BUFFER_ENABLE_N_OUT(BUFFER_ENABLE_N_OUT),
    .BUS_READY_N_IN(BUS_READY_N_IN), .BUS_OWNED_N_OUT(BUS_OWNED_N_OUT),
    .DIRECT_IO_SELECT_OUT(DIRECT_IO_SELECT_OUT)
);
`default_nettype wire

/* tb/hbd_slave_model.sv */
// host memory model on the far side of the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module hbd_slave_model (
    input wire logic clk_in,
    input wire logic [7:0] wait_in,
    input wire logic ale_in,
    input wire logic xal_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] hi_in,
    input wire logic hi_oe_in,
    input wire logic [7:0] lo_in,
    input wire logic lo_oe_in,
    input wire logic ph_in,
    input wire logic pl_in,
    output wire logic [7:0] hi_out,
    output wire logic [7:0] lo_out,
    output wire logic ph_out,
    output wire logic pl_out,
    output wire logic rdy_n_out,
    output wire logic [17:0] wword_out,
    output wire logic wstb_out,
    output wire logic [7:0] xcnt_out,
    output wire logic [31:0] addr_out
);
    reg [31:0] addr_r = 32'h0;
    reg [7:0] xcnt_r = 8'h0;
    reg [7:0] wcnt_r = 8'h0;
    reg [17:0] ww_r = 18'h0;
    reg prev_wr_r = 1'h1;
    reg prev_xal_r = 1'h0;
    reg flt_r = 1'h0;
    reg rdy_n_r = 1'h1;
    reg wstb_r = 1'h0;
    wire [15:0] d = addr_r[15:0] ^ 16'h5a3c;
    wire drv = !rd_n_in;
    // data stays up until the read strobe rises; freed lines toggle, never a stale byte
    assign hi_out = hi_oe_in ? hi_in : (drv ? d[15:8] : {8{flt_r}});
    assign lo_out = lo_oe_in ? lo_in : (drv ? d[7:0] : {8{~flt_r}});
    assign ph_out = hi_oe_in ? ph_in : (drv ? ~^d[15:8] : flt_r);
    assign pl_out = lo_oe_in ? pl_in : (drv ? ~^d[7:0] : ~flt_r);
    assign rdy_n_out = rdy_n_r;
    assign wword_out = ww_r;
    assign wstb_out = wstb_r;
    assign xcnt_out = xcnt_r;
    assign addr_out = addr_r;
    always @(posedge clk_in) begin
        flt_r <= ~flt_r;
        prev_wr_r <= wr_n_in;
        prev_xal_r <= xal_in;
        wstb_r <= !prev_wr_r && wr_n_in;
        if (!prev_wr_r && wr_n_in) ww_r <= {ph_in, pl_in, hi_in, lo_in};
        if (xal_in) addr_r[31:16] <= {hi_in, lo_in};
        if (xal_in && !prev_xal_r) xcnt_r <= xcnt_r + 8'h1;
        if (ale_in) addr_r[15:0] <= {hi_in, lo_in};
        // ready only after data is shown, so late ready never precedes valid data
        if (!rd_n_in || !wr_n_in) begin
            rdy_n_r <= (wcnt_r < wait_in) ? 1'h1 : 1'h0;
            wcnt_r <= wcnt_r + 8'h1;
        end else begin
            rdy_n_r <= 1'h1;
            wcnt_r <= 8'h0;
        end
    end
endmodule
`default_nettype wire

/* tb/hbd_seq_top_test.sv */
// self-checking bench for the dma cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module hbd_seq_top_test;
    reg clk = 1'h0, srst = 1'h1, start = 1'h0, rnw = 1'h0, burst = 1'h0, bus8 = 1'h0;
    reg wvalid = 1'h0, cs_n = 1'h1, bhe_i = 1'h0, bhe_seen = 1'h0, hold_seen = 1'h0;
    reg [31:0] addr = 32'h0;
    reg [15:0] cnt = 16'h0;
    reg [17:0] wword = 18'h0;
    reg [7:0] wt = 8'h0;
    reg [17:0] rq[$], wq[$];
    integer n_mismatch = 0, checks_done = 0;
    wire wready, rvalid, done, hi_oe, lo_oe, ph_o, pl_o, ph_i, pl_i, ale, xal, rd_n, wr_n;
    wire rdy_n, own_n, dio_sel, bhe_o, bhe_oe, dio_bh, wstb, busy, soe;
    wire [7:0] hi_o, lo_o, hi_i, lo_i, xcnt;
    wire [17:0] rword, mword;
    wire [31:0] maddr;
    hbd_seq_top uut (
        .CLK_IN(clk), .SRST_IN(srst), .DMA_START_IN(start), .DMA_ADDR_IN(addr),
        .DMA_COUNT_IN(cnt), .DMA_RNW_IN(rnw), .BURST_MODE_IN(burst), .BUS8_MODE_IN(bus8),
        .DMA_BUSY_OUT(busy), .DMA_DONE_OUT(done), .WR_WORD_IN(wword), .WR_VALID_IN(wvalid),
        .WR_READY_OUT(wready), .RD_WORD_OUT(rword), .RD_VALID_OUT(rvalid),
        .HOST_BUS_CLOCK_OUT(), .ADDR_DATA_HIGH_IN(hi_i), .ADDR_DATA_HIGH_OUT(hi_o),
        .ADDR_DATA_HIGH_OE_OUT(hi_oe), .ADDR_DATA_LOW_IN(lo_i), .ADDR_DATA_LOW_OUT(lo_o),
        .ADDR_DATA_LOW_OE_OUT(lo_oe), .PARITY_HIGH_IN(ph_i), .PARITY_HIGH_OUT(ph_o),
        .PARITY_LOW_IN(pl_i), .PARITY_LOW_OUT(pl_o), .ADDR_LATCH_STROBE_OUT(ale),
        .EXT_ADDR_LATCH_STROBE_OUT(xal), .READ_STROBE_N_OUT(rd_n), .WRITE_STROBE_N_OUT(wr_n),
        .STROBE_OE_OUT(soe), .BUFFER_ENABLE_N_OUT(), .BUS_READY_N_IN(rdy_n),
        .BUS_OWNED_N_OUT(own_n), .CHIP_SELECT_N_IN(cs_n), .DIRECT_IO_SELECT_OUT(dio_sel),
        .BYTE_HIGH_RNW_IN(bhe_i), .BYTE_HIGH_RNW_OUT(bhe_o), .BYTE_HIGH_RNW_OE_OUT(bhe_oe),
        .DIRECT_IO_BYTE_HIGH_OUT(dio_bh)
    );
    hbd_slave_model slave (
        .clk_in(clk), .wait_in(wt), .ale_in(ale), .xal_in(xal), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .hi_in(hi_o), .hi_oe_in(hi_oe), .lo_in(lo_o), .lo_oe_in(lo_oe), .ph_in(ph_o),
        .pl_in(pl_o), .hi_out(hi_i), .lo_out(lo_i), .ph_out(ph_i), .pl_out(pl_i),
        .rdy_n_out(rdy_n), .wword_out(mword), .wstb_out(wstb), .xcnt_out(xcnt), .addr_out(maddr)
    );
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (rvalid === 1'h1) rq.push_back(rword);
        if (wstb === 1'h1) wq.push_back(mword);
        if (bhe_oe === 1'h1 && bhe_o === 1'h1) bhe_seen <= 1'h1;
        // only the 8-bit job leaves the high lines driven alone, just after t4
        if (hi_oe === 1'h1 && lo_oe === 1'h0 && hi_o === 8'h34) hold_seen <= 1'h1;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task push(input logic [17:0] w);
        @(negedge clk);
        wword = w;
        wvalid = 1'h1;
    endtask
    // chip select stays low throughout, so a leak shows while the bus is owned
    task run_job(input [31:0] a, input [15:0] n, input r, input b, input e, input [7:0] w);
        integer i, n_own, bad;
        @(negedge clk);
        wvalid = 1'h0;
        {addr, cnt, rnw, burst, bus8, wt} = {a, n, r, b, e, w};
        start = 1'h1;
        @(negedge clk);
        start = 1'h0;
        n_own = 0;
        bad = 0;
        for (i = 0; i < 3000 && done !== 1'h1; i = i + 1) begin
            @(negedge clk);
            // strobe drivers may be on only while the bus is ours and a job runs
            if (soe === 1'h1) n_own = n_own + 1;
            if (soe === 1'h1 && {own_n, busy} !== 2'h1) bad = bad + 1;
        end
        if (i >= 3000) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch at %0t: got %h expected %h", $time, i, 0);
            give_verdict;
        end
        chk(own_n, 1);
        chk(n_own != 0, 1);
        chk(bad, 0);
        chk({soe, busy}, 0);
        repeat (3) @(negedge clk);
        chk(dio_sel, 1);
    endtask
    task rd_job(input [31:0] a, input b, input [7:0] w, input [7:0] nx);
        reg [7:0] x0;
        reg [15:0] d;
        integer i;
        x0 = xcnt;
        rq = {};
        run_job(a, 16'h3, 1'h1, b, 1'h0, w);
        chk(xcnt - x0, nx);
        chk(maddr, a + 32'h4);
        chk(rq.size(), 3);
        for (i = 0; i < 3; i = i + 1) begin
            d = (a[15:0] + 2 * i) ^ 16'h5a3c;
            chk(rq[i], {~^d[15:8], ~^d[7:0], d});
        end
    endtask
    task t_steal_read;
        rd_job(32'h0000_0100, 1'h0, 8'h0, 8'h3);
        $display("test steal_read done");
    endtask
    task t_burst_slow_read;
        rd_job(32'h0001_fffe, 1'h1, 8'h9, 8'h2);
        $display("test burst_slow_read done");
    endtask
    task t_write_full;
        integer i;
        reg [7:0] x0;
        x0 = xcnt;
        wq = {};
        for (i = 0; i < 16; i = i + 1) push({i[1:0], 16'hc000 | i[15:0]});
        @(negedge clk);
        chk(wready, 0);
        run_job(32'h0001_fff0, 16'h10, 1'h0, 1'h1, 1'h0, 8'h6);
        chk(xcnt - x0, 2);
        chk(maddr, 32'h0002_000e);
        chk(wready, 1);
        chk(wq.size(), 16);
        for (i = 0; i < 16; i = i + 1) chk(wq[i], {i[1:0], 16'hc000 | i[15:0]});
        $display("test write_full done");
    endtask
    task t_bus8_write;
        wq = {};
        push(18'h000a1);
        push(18'h000a2);
        run_job(32'h0000_3456, 16'h2, 1'h0, 1'h0, 1'h1, 8'h1);
        chk(bhe_seen, 1);
        chk(hold_seen, 1);
        chk(wq[0][15:0], 16'h34a1);
        chk(wq[1][15:0], 16'h34a2);
        chk(maddr, 32'h0000_3457);
        bhe_i = 1'h1;
        repeat (3) @(negedge clk);
        chk(dio_bh, 0);
        bus8 = 1'h0;
        repeat (3) @(negedge clk);
        chk(dio_bh, 1);
        $display("test bus8_write done");
    endtask
    initial begin
        repeat (6) @(posedge clk);
        @(negedge clk);
        srst = 1'h0;
        cs_n = 1'h0;
        t_steal_read;
        t_burst_slow_read;
        t_write_full;
        t_bus8_write;
        give_verdict;
    end
endmodule
`default_nettype wire
